// >>> core/fis_edge.sv
// fis_edge: flags any change of a synchronised level vector
// assumes inputs already in the sys_clk domain
`timescale 1ns/1ps
module fis_edge import fis_pkg::*; #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // levels and change pulse
  input wire logic [W-1:0] lvl,
  output logic changed
);
  logic [W-1:0] prev_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= lvl;
    end
  end
  assign changed = |(lvl ^ prev_reg);
endmodule // fis_edge

// >>> core/fis_pkg.sv
// fis_pkg: shared constants and types for fault and interrupt status block
// assumes a 125 MHz sys_clk and an AHB-Lite register port
package fis_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // short-circuit sensing blanking after activation, in microseconds
  localparam int unsigned SCP_BLANK_US = 4000;
  localparam int unsigned SCP_BLANK_CYC = SCP_BLANK_US * CLK_MHZ;
  // byte addresses of the registers
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_IEN = 8'h0C;
  localparam logic [7:0] ADDR_SINKSEL = 8'h14;
  localparam logic [7:0] ADDR_SINKCTL = 8'h6C;
  localparam logic [7:0] ADDR_FAULT = 8'h40;
  // status bit positions
  localparam int unsigned BIT_BLOFF = 0;
  localparam int unsigned BIT_CMP1 = 1;
  localparam int unsigned BIT_CMP2 = 2;
  localparam int unsigned BIT_OVP = 3;
  localparam int unsigned BIT_TSD = 4;
  localparam int unsigned BIT_SCP = 5;
  localparam int unsigned NFLAG = 6;
  // mode register fields
  localparam int unsigned BIT_STBY_REL = 0;
  localparam int unsigned BIT_GAIN_DOWNSHIFT_DISABLE = 1;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int unsigned SYNC_IN = 6;

  typedef struct packed {
    logic fade_done;
    logic scp_sense;
    logic tsd_low;
    logic tsd_high;
    logic ovp_high;
    logic vreg_reached;
  } fis_analog_t;

  typedef struct packed {
    logic [3:0] lvl1;
    logic [3:0] lvl2;
  } fis_levels_t;

  typedef enum logic [3:0] {
    ST_STBY = 4'h1,
    ST_START = 4'h2,
    ST_RUN = 4'h4,
    ST_FAULT = 4'h8
  } fis_state_t;
endpackage

// >>> core/fis_sync.sv
// fis_sync: three-flop synchroniser with agreement filter per bit
// assumes asynchronous inputs; output changes when stages 2 and 3 agree
`timescale 1ns/1ps
module fis_sync import fis_pkg::*; #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        dout[i] <= 1'b0;
      end else if (s2_reg[i] == s3_reg[i]) begin
        dout[i] <= s3_reg[i];
      end
    end
  end
endmodule // fis_sync

// >>> core/fis_top.sv
// fis_top: fault supervision and interrupt status with AHB-Lite slave
// assumes analog monitors arrive asynchronously; fade end comes from
// logic on sys_clk
`timescale 1ns/1ps
module fis_top import fis_pkg::*; #(
  parameter int unsigned SCP_BLANK = SCP_BLANK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog monitors and comparator levels
  input wire fis_analog_t mon,
  input wire fis_levels_t levels,
  // controls to the power stage
  output logic pump_en,
  output logic standby,
  output logic soft_start,
  output logic gain_downshift_disable,
  // interrupt pin
  output logic irq_out_n
);
  logic [SYNC_IN-1:0] an_raw, an_s;
  logic [7:0] lv_s;
  logic fade_done;
  logic cmp1_chg, cmp2_chg;
  logic ovp_s, tsd_hi_s, tsd_lo_s, scp_s, vreg_s;

  assign an_raw = {mon.scp_sense, mon.tsd_low, mon.tsd_high,
                   mon.ovp_high, mon.vreg_reached, 1'b0};
  assign fade_done = mon.fade_done;

  fis_sync #(.W(SYNC_IN)) u_sync_an (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(an_raw),
    .dout(an_s)
  );
  fis_sync #(.W(8)) u_sync_lv (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .din(levels),
    .dout(lv_s)
  );
  fis_edge #(.W(4)) u_edge1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .lvl(lv_s[7:4]),
    .changed(cmp1_chg)
  );
  fis_edge #(.W(4)) u_edge2 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .lvl(lv_s[3:0]),
    .changed(cmp2_chg)
  );

  assign scp_s = an_s[5];
  // tsd_low high means die still above the restart limit
  assign tsd_lo_s = an_s[4];
  assign tsd_hi_s = an_s[3];
  assign ovp_s = an_s[2];
  // regulation level reached is handled in analog; no flag source
  assign vreg_s = an_s[1];

  // ---------------- bus slave ----------------
  logic dp_wr_reg, dp_rd_reg;
  logic [7:0] dp_addr_reg;
  logic aph;
  assign aph = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_wr_reg <= aph && hwrite;
      dp_rd_reg <= aph && !hwrite;
      dp_addr_reg <= aph ? haddr[7:0] : dp_addr_reg;
    end
  end

  logic wr_mode, wr_stat, wr_ien, wr_sel, wr_ctl;
  assign wr_mode = dp_wr_reg && dp_addr_reg == ADDR_MODE;
  assign wr_stat = dp_wr_reg && dp_addr_reg == ADDR_STAT;
  assign wr_ien = dp_wr_reg && dp_addr_reg == ADDR_IEN;
  assign wr_sel = dp_wr_reg && dp_addr_reg == ADDR_SINKSEL;
  assign wr_ctl = dp_wr_reg && dp_addr_reg == ADDR_SINKCTL;

  // ---------------- registers ----------------
  logic [7:0] mode_reg, ien_reg, sinksel_reg, sinkctl_reg;
  logic [NFLAG-1:0] stat_reg, stat_next, set_vec;
  logic restart_req;

  // sink setup is host policy; the block only stores it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sinksel_reg <= RST_VAL[7:0];
      sinkctl_reg <= RST_VAL[7:0];
    end else begin
      if (wr_sel) sinksel_reg <= hwdata[7:0];
      if (wr_ctl) sinkctl_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ien_reg <= RST_VAL[7:0];
    end else if (wr_ien) begin
      ien_reg <= {2'h0, hwdata[NFLAG-1:0]};
    end
  end

  // every write of standby release = 1 is a restart request
  logic fault_entry, tsd_entry;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg <= RST_VAL[7:0];
    end else if (wr_mode) begin
      mode_reg <= {6'h00, hwdata[BIT_GAIN_DOWNSHIFT_DISABLE], hwdata[BIT_STBY_REL]};
    end else if (fault_entry) begin
      mode_reg[BIT_STBY_REL] <= 1'b0;
    end
  end
  assign restart_req = wr_mode && hwdata[BIT_STBY_REL];

  // ---------------- fault state machine ----------------
  fis_state_t st_reg, st_next;
  logic [$clog2(SCP_BLANK+1)-1:0] blank_cnt_reg;
  logic blank_done;
  assign blank_done = blank_cnt_reg == '0;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_STBY: begin
        // hot die blocks restart until below the lower limit
        if (restart_req && !tsd_lo_s && !tsd_hi_s) st_next = ST_START;
      end
      ST_START: begin
        if (tsd_hi_s) st_next = ST_FAULT;
        else if (blank_done) st_next = ST_RUN;
      end
      ST_RUN: begin
        if (tsd_hi_s) st_next = ST_FAULT;
        else if (scp_s) st_next = ST_FAULT;
        else if (!mode_reg[BIT_STBY_REL]) st_next = ST_STBY;
      end
      ST_FAULT: begin
        st_next = ST_STBY;
      end
      default: st_next = ST_STBY;
    endcase
  end
  assign fault_entry = st_next == ST_FAULT && st_reg != ST_FAULT;
  assign tsd_entry = fault_entry && tsd_hi_s;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= ST_STBY;
    end else begin
      st_reg <= st_next;
    end
  end

  // short sensing ignored while the soft start runs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blank_cnt_reg <= '0;
    end else if (st_next == ST_START && st_reg != ST_START) begin
      blank_cnt_reg <= ($clog2(SCP_BLANK+1))'(SCP_BLANK - 1);
    end else if (!blank_done) begin
      blank_cnt_reg <= blank_cnt_reg - 1'b1;
    end
  end

  // ---------------- overvoltage ----------------
  logic ovp_prev_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovp_prev_reg <= 1'b0;
    end else begin
      ovp_prev_reg <= ovp_s;
    end
  end

  // ---------------- flag sources ----------------
  always_comb begin
    set_vec = '0;
    set_vec[BIT_BLOFF] = fade_done;
    set_vec[BIT_CMP1] = cmp1_chg;
    set_vec[BIT_CMP2] = cmp2_chg;
    set_vec[BIT_OVP] = ovp_s && !ovp_prev_reg;
    // still hot after a shutdown keeps re-raising the flag
    set_vec[BIT_TSD] = tsd_entry ||
                       (st_reg == ST_STBY && tsd_lo_s);
    set_vec[BIT_SCP] = fault_entry && !tsd_hi_s;
  end

  // set wins over a simultaneous write-one clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) stat_next = stat_reg & ~hwdata[NFLAG-1:0];
    stat_next = stat_next | set_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(stat_next & ien_reg[NFLAG-1:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pump_en <= 1'b0;
      standby <= 1'b1;
      soft_start <= 1'b0;
      gain_downshift_disable <= 1'b0;
    end else begin
      // pump stops only while over threshold; other paths unaffected
      pump_en <= (st_next == ST_RUN || st_next == ST_START)
                 && !ovp_s;
      standby <= st_next == ST_STBY || st_next == ST_FAULT;
      soft_start <= st_next == ST_START;
      gain_downshift_disable <= mode_reg[BIT_GAIN_DOWNSHIFT_DISABLE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (aph && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_MODE: hrdata <= {24'h000000, mode_reg};
        ADDR_STAT: hrdata <= {26'h0, stat_next};
        ADDR_IEN: hrdata <= {24'h000000, ien_reg};
        ADDR_SINKSEL: hrdata <= {24'h000000, sinksel_reg};
        ADDR_SINKCTL: hrdata <= {24'h000000, sinkctl_reg};
        ADDR_FAULT: hrdata <= {28'h0000000, st_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------- assertions ----------------
  a_irq_follows_mask: assert property (@(posedge sys_clk) disable iff
    (sys_rst) irq_out_n == !(|($past(stat_next) & $past(ien_reg[5:0]))))
    else $error("irq pin disagrees with enabled flags");
  a_irq_held_pending: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (|(stat_reg & ien_reg[5:0]) && !wr_stat && !wr_ien)
    |=> !irq_out_n) else $error("irq released while pending");
  a_ovp_flag_set: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (ovp_s && !ovp_prev_reg) |=> stat_reg[BIT_OVP])
    else $error("overvoltage entry not flagged");
  a_ovp_pump_off: assert property (@(posedge sys_clk) disable iff
    (sys_rst) ovp_s |=> !pump_en)
    else $error("pump running in overvoltage");
  a_tsd_standby: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (st_reg == ST_RUN && tsd_hi_s) |=> ##1 standby &&
    stat_reg[BIT_TSD]) else $error("thermal entry missed");
  a_hot_no_restart: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (st_reg == ST_STBY && tsd_lo_s) |=> st_reg != ST_START)
    else $error("restart while hot");
  a_tsd_reflag: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (st_reg == ST_STBY && tsd_lo_s) |=> stat_reg[BIT_TSD])
    else $error("thermal flag not re-raised");
  a_clear_works: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (wr_stat && hwdata[BIT_CMP1] && !cmp1_chg)
    |=> !stat_reg[BIT_CMP1]) else $error("write one did not clear");
  a_cmp_flag_set: assert property (@(posedge sys_clk) disable iff
    (sys_rst) cmp1_chg |=> stat_reg[BIT_CMP1])
    else $error("comparator change not flagged");
  a_blank_scp: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (st_reg == ST_START && !tsd_hi_s) |=> !stat_reg[BIT_SCP]
    || $past(stat_reg[BIT_SCP])) else $error("short seen in blank");
  // regulation is analog only; the pump must keep running through it
  a_vreg_pump_on: assert property (@(posedge sys_clk) disable iff
    (sys_rst) (st_reg == ST_RUN && st_next == ST_RUN && vreg_s && !ovp_s)
    |=> pump_en) else $error("pump stopped at regulation level");
  c_ovp_event: cover property (@(posedge sys_clk) ovp_s && !ovp_prev_reg);
  c_tsd_entry: cover property (@(posedge sys_clk) tsd_entry);
  c_restart: cover property (@(posedge sys_clk) st_reg == ST_START);
  c_irq_low: cover property (@(posedge sys_clk) !irq_out_n);
endmodule // fis_top

// >>> dv/fis_host.sv
// fis_host: host processor model, single-word AHB-Lite master
// assumes hready is the one slave's hreadyout and resp is OKAY
`timescale 1ns/1ps
module fis_host import fis_pkg::*; (
  // clock
  input wire logic sys_clk,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // interrupt pin, serviced by polling the status register
  input wire logic irq_out_n
);
  int timeouts = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // a dead slave must not hang the run, so the wait is bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) timeouts++;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
  // unused sinks go independent first, then off, or the pump loses out
  task automatic park_sinks();
    wr(ADDR_SINKSEL, 32'h0000_007F);
    wr(ADDR_SINKCTL, 32'h0000_0000);
  endtask
  // small fly caps: gain downshift off, part left in standby
  task automatic small_caps();
    wr(ADDR_MODE, 32'h0000_0002);
  endtask
  task automatic ack(input logic [31:0] m);
    wr(ADDR_STAT, m);
  endtask
  // restart request; the device decides whether it is cool enough
  task automatic restart_part();
    wr(ADDR_MODE, 32'h0000_0003);
  endtask
  // interrupt pin level as the host sees it
  task automatic irq_level(output logic l);
    l = irq_out_n;
  endtask
endmodule // fis_host

// >>> dv/fis_top_bench.sv
// fis_top_bench: scenarios for the fault and interrupt status block
// assumes the host model drives the bus and blanking is cut to 20
`timescale 1ns/1ps
module fis_top_bench import fis_pkg::*;;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  fis_analog_t mon = '0;
  fis_levels_t levels = '0;
  logic hsel, hwrite, hreadyout, hresp, irq_out_n;
  logic pump_en, standby, soft_start, gdd;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int miscompares = 0;
  int check_count = 0;
  always #4 sys_clk = ~sys_clk;
  fis_top #(.SCP_BLANK(20)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mon(mon), .levels(levels),
    .pump_en(pump_en), .standby(standby), .soft_start(soft_start),
    .gain_downshift_disable(gdd), .irq_out_n(irq_out_n));
  fis_host host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .irq_out_n(irq_out_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stat(input logic [31:0] exp);
    host.rd(ADDR_STAT, d);
    chk(d, exp, "status");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    miscompares += host.timeouts;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset();
    stat(32'h0);
    host.rd(ADDR_FAULT, d);
    chk(d, {28'h0, ST_STBY}, "state");
    chk(irq_out_n, 1'b1, "irq idle");
    chk(standby, 1'b1, "standby");
    chk(hreadyout, 1'b1, "bus ready");
    chk(hresp, 1'b0, "bus okay");
    host.rd(8'h30, d);
    chk(d, 32'h0, "unmapped");
    host.park_sinks();
    host.small_caps();
    // the write lands at the data phase end; the pin follows one edge later
    cyc(2);
    chk(gdd, 1'b1, "gdd");
    chk(hresp, 1'b0, "write okay");
    $display("test reset done");
  endtask
  task automatic t_fade();
    logic p;
    host.wr(ADDR_IEN, 32'h3F);
    for (int i = 0; i < 2; i++) begin
      mon.fade_done <= 1'b1;
      cyc(1);
      mon.fade_done <= 1'b0;
      cyc(2);
      stat(32'h1);
      chk(irq_out_n, 1'b0, "irq on");
      host.irq_level(p);
      chk(p, 1'b0, "host sees irq");
      host.wr(ADDR_IEN, 32'h3E);
      cyc(2);
      chk(irq_out_n, 1'b1, "masked");
      host.wr(ADDR_IEN, 32'h3F);
      host.ack(32'h3E);
      stat(32'h1);
      host.ack(32'h1);
      stat(32'h0);
      cyc(2);
      chk(irq_out_n, 1'b1, "irq off");
    end
    mon.vreg_reached <= 1'b1;
    cyc(8);
    stat(32'h0);
    $display("test fade done");
  endtask
  // each level bit of both sensors, rising then falling
  task automatic t_cmp();
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 2; j++) begin
        levels[k] <= ~levels[k];
        cyc(8);
        stat(k >= 4 ? 32'h2 : 32'h4);
        host.ack(32'h6);
      end
    end
    $display("test comparators done");
  endtask
  task automatic t_ovp();
    host.restart_part();
    cyc(1);
    chk(soft_start, 1'b1, "soft start");
    mon.scp_sense <= 1'b1;
    cyc(6);
    mon.scp_sense <= 1'b0;
    stat(32'h0);
    cyc(30);
    host.rd(ADDR_FAULT, d);
    chk(d, {28'h0, ST_RUN}, "run");
    for (int i = 0; i < 2; i++) begin
      mon.ovp_high <= 1'b1;
      cyc(8);
      chk(pump_en, 1'b0, "pump off");
      chk(standby, 1'b0, "still up");
      stat(32'h8);
      mon.ovp_high <= 1'b0;
      cyc(8);
      chk(pump_en, 1'b1, "pump back");
      host.ack(32'h8);
    end
    $display("test overvoltage done");
  endtask
  task automatic t_hot();
    mon.tsd_low <= 1'b1;
    mon.tsd_high <= 1'b1;
    cyc(8);
    chk(standby, 1'b1, "standby");
    stat(32'h10);
    mon.tsd_high <= 1'b0;
    host.ack(32'h10);
    stat(32'h10);
    host.restart_part();
    cyc(30);
    host.rd(ADDR_FAULT, d);
    chk(d, {28'h0, ST_STBY}, "hot hold");
    host.small_caps();
    mon.tsd_low <= 1'b0;
    cyc(8);
    host.ack(32'h10);
    cyc(8);
    stat(32'h0);
    host.restart_part();
    cyc(30);
    mon.scp_sense <= 1'b1;
    cyc(8);
    stat(32'h20);
    chk(standby, 1'b1, "short stby");
    mon.scp_sense <= 1'b0;
    host.ack(32'h20);
    host.restart_part();
    cyc(1);
    chk(soft_start, 1'b1, "restart");
    $display("test thermal and short done");
  endtask
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
  // a bus wait that ran out ends the run at once
  always @(posedge sys_clk) begin
    if (host.timeouts != 0) give_verdict();
  end
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    t_reset();
    t_fade();
    t_cmp();
    t_ovp();
    t_hot();
    give_verdict();
  end
endmodule // fis_top_bench
